// >>> core/tac_thermal_alarm.sv
// Operation
// - Drive hot alarm when any core reaches maximum safe temperature.
// - With throttle enabled, throttle stays active while hot alarm asserted.
// - Interrupt selectable on asserting or deasserting hot alarm edge.
// - External hot alarm input activates throttle in both cores if enabled.
// - Externally forced throttle lasts until the board releases the line.
// - Hot alarm line is shared bidirectional; device and board may drive.
// - Catastrophic heat latches shutdown output and halts, regardless of enable.
// - Shutdown output independent of activity; no bus cycles issued.
// - Fan target offset readable; reader adds it to a 50 C base.
// - Fan target offset lies between 0x00 and 0x1E.
// - Hot alarm asserts even when throttling is disabled.
// - Own-heat throttle ends only after cooling and hysteresis timer expiry.
`timescale 1ns/1ps
`default_nettype none
module tac_thermal_alarm
	import tac_pkg::*;
#(
	parameter int HYST_COUNT = HYST_CYCLES,
	parameter logic [7:0] FAN_OFFSET = FAN_OFFSET_DEFAULT
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire tac_cfg_s cfg_i,
	input wire tac_sense_s sense_i,
	input wire logic hot_alarm_n_i,
	output logic hot_alarm_n_o,
	output logic hot_alarm_oe_o,
	output logic thermal_shutdown_n_o,
	output logic core_halt_o,
	output logic [NUM_CORES-1:0] thermal_clock_throttle_o,
	output logic irq_o,
	output logic [7:0] fan_offset_o
);
	logic ext_meta_reg;
	logic ext_sync_reg;
	logic hot_reg;
	logic hot_prev_reg;
	logic hot_prev2_reg;
	logic drive_n_reg;
	logic trip_reg;
	logic shut_n_reg;
	logic ext_throt_reg;
	logic own_throt_reg;
	logic [HYST_W-1:0] hyst_reg;
	logic [HYST_W-1:0] hyst_next;
	logic [NUM_CORES-1:0] throttle_reg;
	logic irq_reg;
	logic [7:0] fan_reg;

	// Decode of hot condition, external request and edges
	wire any_hot = |sense_i.at_max;
	wire any_cat = |sense_i.catastrophic;
	// Own drive is masked for as long as it takes to cross the synchroniser
	wire own_drive = hot_reg | hot_prev_reg | hot_prev2_reg;
	// Line low while we are not driving means the board drives it
	wire ext_req = ext_sync_reg & ~own_drive;
	wire rise_hot = hot_reg & ~hot_prev_reg;
	wire fall_hot = ~hot_reg & hot_prev_reg;
	wire irq_pulse = ((cfg_i.irq_mode == TAC_IRQ_ASSERT) & rise_hot) |
		((cfg_i.irq_mode == TAC_IRQ_DEASSERT) & fall_hot) |
		((cfg_i.irq_mode == TAC_IRQ_BOTH) & (rise_hot | fall_hot));
	wire own_active = any_hot | (hyst_reg != '0);
	wire throt_any = cfg_i.throttle_en & (own_throt_reg | ext_throt_reg);
	wire [7:0] fan_clamped = (FAN_OFFSET > FAN_OFFSET_MAX) ?
		FAN_OFFSET_MAX : FAN_OFFSET;

	// Hysteresis counter reloads while hot, counts down after cooling
	always_comb begin
		hyst_next = hyst_reg;
		if (any_hot) begin
			hyst_next = HYST_W'(HYST_COUNT);
		end else if (hyst_reg != '0) begin
			hyst_next = hyst_reg - 1'b1;
		end
	end

	// Two-stage synchroniser for the shared line, active high internally
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
		end else begin
			ext_meta_reg <= ~hot_alarm_n_i;
			ext_sync_reg <= ext_meta_reg;
		end
	end

	// Hot alarm report, independent of throttle enable
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hot_reg <= 1'b0;
			hot_prev_reg <= 1'b0;
			hot_prev2_reg <= 1'b0;
			drive_n_reg <= 1'b1;
		end else begin
			hot_reg <= any_hot;
			hot_prev_reg <= hot_reg;
			hot_prev2_reg <= hot_prev_reg;
			drive_n_reg <= ~any_hot;
		end
	end

	// Throttle sources: own heat with hysteresis, external request
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hyst_reg <= '0;
			own_throt_reg <= 1'b0;
			ext_throt_reg <= 1'b0;
		end else begin
			hyst_reg <= hyst_next;
			own_throt_reg <= own_active;
			ext_throt_reg <= ext_req;
		end
	end

	// Throttle applies to both cores alike
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			throttle_reg <= '0;
		end else begin
			throttle_reg <= {NUM_CORES{throt_any}};
		end
	end

	// Catastrophic trip latches until reset, no bus activity involved
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trip_reg <= 1'b0;
			shut_n_reg <= 1'b1;
		end else if (any_cat) begin
			trip_reg <= 1'b1;
			shut_n_reg <= 1'b0;
		end
	end

	// Interrupt pulse and fan offset value
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_reg <= 1'b0;
			fan_reg <= FAN_OFFSET_MIN;
		end else begin
			irq_reg <= irq_pulse;
			fan_reg <= fan_clamped;
		end
	end

	// Open-drain style drive: low with enable while hot
	assign hot_alarm_n_o = drive_n_reg;
	assign hot_alarm_oe_o = hot_reg;
	assign thermal_shutdown_n_o = shut_n_reg;
	assign core_halt_o = trip_reg;
	assign thermal_clock_throttle_o = throttle_reg;
	assign irq_o = irq_reg;
	assign fan_offset_o = fan_reg;

	// Assertions
	// Alarm output follows the hot condition one cycle later
	a_hot_follows: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) any_hot |=> hot_alarm_oe_o)
		else $error("hot alarm not driven when hot");
	// Alarm drops once no core is hot
	a_hot_release: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) !any_hot |=> !hot_alarm_oe_o)
		else $error("hot alarm held while cool");
	// Alarm is reported even with throttling disabled
	a_hot_noenable: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_hot && !cfg_i.throttle_en) |=> hot_alarm_oe_o)
		else $error("hot alarm missing without enable");
	// Own hot condition throttles both cores
	a_throt_hot: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(hot_reg && cfg_i.throttle_en) |-> ##2 (!cfg_i.throttle_en ||
		&thermal_clock_throttle_o))
		else $error("throttle off while hot");
	// Throttle is fully off while the feature is disabled
	a_throt_off: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		!cfg_i.throttle_en |=> !(|thermal_clock_throttle_o))
		else $error("throttle active while disabled");
	// Throttle always has an own or external cause
	a_throt_cause: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(|thermal_clock_throttle_o) |-> $past(own_throt_reg || ext_throt_reg))
		else $error("throttle without cause");
	// Both cores throttle alike
	a_throt_same: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(&thermal_clock_throttle_o) || !(|thermal_clock_throttle_o))
		else $error("cores throttled differently");
	// Interrupt on the asserting edge
	a_irq_rise: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(rise_hot && cfg_i.irq_mode == TAC_IRQ_ASSERT) |=> irq_o)
		else $error("no interrupt on asserting edge");
	// Interrupt on the deasserting edge
	a_irq_fall: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(fall_hot && cfg_i.irq_mode == TAC_IRQ_DEASSERT) |=> irq_o)
		else $error("no interrupt on deasserting edge");
	// Interrupt on either edge when both are selected
	a_irq_both: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		((rise_hot || fall_hot) && cfg_i.irq_mode == TAC_IRQ_BOTH) |=> irq_o)
		else $error("no interrupt in both-edge mode");
	// No interrupt while interrupts are switched off
	a_irq_off: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(cfg_i.irq_mode == TAC_IRQ_OFF) |=> !irq_o)
		else $error("interrupt while off");
	// Every interrupt follows an alarm edge
	a_irq_cause: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		irq_o |-> $past(rise_hot) || $past(fall_hot))
		else $error("spurious interrupt");
	// External request throttles both cores
	a_ext_throt: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(ext_req && cfg_i.throttle_en) |=> ##1 (!cfg_i.throttle_en ||
		&thermal_clock_throttle_o))
		else $error("external request ignored");
	// Held external throttle reaches the cores while enabled
	a_ext_both: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(ext_throt_reg && cfg_i.throttle_en) |=> &thermal_clock_throttle_o)
		else $error("external throttle not applied");
	// External throttle stays while the line is held
	a_ext_hold: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) ext_req [*2] |-> ext_throt_reg)
		else $error("external throttle dropped early");
	// External throttle ends once the line is released
	a_ext_release: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) !ext_req |=> !ext_throt_reg)
		else $error("external throttle held after release");
	// Shutdown and halt stay latched
	a_trip_sticky: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		!thermal_shutdown_n_o |=> !thermal_shutdown_n_o && core_halt_o)
		else $error("shutdown released");
	// Halt and shutdown pin always agree
	a_trip_halt: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) core_halt_o == !thermal_shutdown_n_o)
		else $error("halt and shutdown disagree");
	// Trip does not wait for the throttle feature
	a_trip_noen: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(any_cat && !cfg_i.throttle_en) |=> core_halt_o)
		else $error("trip gated by enable");
	// Catastrophic heat trips one cycle later
	a_trip_set: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) any_cat |=> !thermal_shutdown_n_o)
		else $error("shutdown not asserted");
	// Trip only ever follows catastrophic heat
	a_trip_cause: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) $fell(thermal_shutdown_n_o) |-> $past(any_cat))
		else $error("shutdown without cause");
	// Throttle outlives the hot condition
	a_hyst_hold: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) $fell(any_hot) |-> ##1 own_throt_reg)
		else $error("throttle ended without hysteresis");
	// Timer reloads while hot
	a_hyst_load: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) any_hot |=> hyst_reg == HYST_W'(HYST_COUNT))
		else $error("hysteresis timer not reloaded");
	// Timer counts down by one once cool
	a_hyst_down: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		(!any_hot && hyst_reg != '0) |=> hyst_reg == $past(hyst_reg) - 1'b1)
		else $error("hysteresis timer miscounts");
	// Own throttle ends only when cool and timer expired
	a_hyst_end: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		$fell(own_throt_reg) |-> $past(!any_hot) && $past(hyst_reg) == '0)
		else $error("throttle ended too soon");
	// Fan offset never leaves its range
	a_fan_range: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) fan_offset_o <= FAN_OFFSET_MAX)
		else $error("fan offset out of range");
	// Oversized offset is clamped to the top of the range
	a_fan_clamp: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		($past(rst_n_i, 2) && FAN_OFFSET > FAN_OFFSET_MAX) |->
		fan_offset_o == FAN_OFFSET_MAX)
		else $error("fan offset not clamped");
	// In-range offset is passed unchanged
	a_fan_pass: assert property (@(posedge clock_i)
		disable iff (!rst_n_i)
		($past(rst_n_i, 2) && FAN_OFFSET <= FAN_OFFSET_MAX) |->
		fan_offset_o == FAN_OFFSET)
		else $error("fan offset altered");
	// Fan offset stays constant after start-up
	a_fan_stable: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) $past(rst_n_i, 2) |-> $stable(fan_offset_o))
		else $error("fan offset changed");
	// Pin is pulled low whenever it is enabled
	a_line_drive: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) hot_alarm_oe_o |-> !hot_alarm_n_o)
		else $error("line enabled but not low");
	// Pin data idles high when released
	a_line_idle: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) !hot_alarm_oe_o |-> hot_alarm_n_o)
		else $error("line data low while released");
	// First synchroniser stage samples the inverted pin
	a_sync_first: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) ext_meta_reg == !$past(hot_alarm_n_i))
		else $error("synchroniser first stage wrong");
	// Second stage follows the first
	a_sync_second: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) ext_sync_reg == $past(ext_meta_reg))
		else $error("synchroniser second stage wrong");
	// Own drive and its synchroniser echo never count as external
	a_no_self: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) (hot_reg || hot_prev_reg) |-> !ext_req)
		else $error("own drive seen as external");

	c_hot: cover property (@(posedge clock_i) disable iff (!rst_n_i) rise_hot);
	c_ext: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(ext_throt_reg));
	c_trip: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(trip_reg));
	c_irq_fall: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		irq_o && $past(fall_hot));
	c_hyst_end: cover property (@(posedge clock_i) disable iff (!rst_n_i)
		$fell(own_throt_reg));
endmodule
`default_nettype wire

// >>> inc/tac_pkg.sv
package tac_pkg;
	// Core count and hysteresis timing
	localparam int NUM_CORES = 2;
	localparam int CLK_PERIOD_NS = 10;
	localparam int HYST_TIME_NS = 1000;
	localparam int HYST_CYCLES = (HYST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HYST_W = 16;
	// Fan target offset range and base
	localparam int FAN_BASE_DEGC = 50;
	localparam logic [7:0] FAN_OFFSET_MIN = 8'h00;
	localparam logic [7:0] FAN_OFFSET_MAX = 8'h1E;
	localparam logic [7:0] FAN_OFFSET_DEFAULT = 8'h00;

	// Interrupt edge selection
	typedef enum logic [1:0] {
		TAC_IRQ_OFF,
		TAC_IRQ_ASSERT,
		TAC_IRQ_DEASSERT,
		TAC_IRQ_BOTH
	} tac_irq_mode_e;

	// Configuration bundle
	typedef struct packed {
		logic throttle_en;
		tac_irq_mode_e irq_mode;
	} tac_cfg_s;

	// Per-core temperature comparator results
	typedef struct packed {
		logic [NUM_CORES-1:0] at_max;
		logic [NUM_CORES-1:0] catastrophic;
	} tac_sense_s;
endpackage

// >>> verification/tac_board_model.sv
`timescale 1ns/1ps
`default_nettype none
module tac_board_model (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic shutdown_n_i,
	output logic pull_oe_o,
	output logic supply_off_o
);
	// Board pulls the shared line low while it wants throttling
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pull_oe_o <= 1'b0;
			supply_off_o <= 1'b0;
		end else begin
			pull_oe_o <= req_i;
			supply_off_o <= supply_off_o | ~shutdown_n_i;
		end
	end
endmodule
`default_nettype wire

// >>> verification/thermal_alarm_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_alarm_control_tb;
	import tac_pkg::*;
	logic clock_i, rst_n_i, req, pull_oe, supply_off;
	logic oe, drv_n, shut_n, halt, irq;
	logic [NUM_CORES-1:0] thr;
	logic [7:0] fan;
	tac_cfg_s cfg;
	tac_sense_s sense;
	int bad_count = 0;
	int n_checks = 0;
	int i;
	// Shared line with pull-up: low when either side pulls
	wire logic line_n = (oe ? drv_n : 1'b1) & ~pull_oe;
	tac_thermal_alarm #(.HYST_COUNT(4), .FAN_OFFSET(8'h2A)) dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_i(cfg), .sense_i(sense),
		.hot_alarm_n_i(line_n), .hot_alarm_n_o(drv_n), .hot_alarm_oe_o(oe),
		.thermal_shutdown_n_o(shut_n), .core_halt_o(halt),
		.thermal_clock_throttle_o(thr), .irq_o(irq), .fan_offset_o(fan));
	tac_board_model board (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.req_i(req), .shutdown_n_i(shut_n), .pull_oe_o(pull_oe),
		.supply_off_o(supply_off));
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic own_alarm();
		cfg = '{1'b1, TAC_IRQ_ASSERT};
		sense.at_max = 2'b01;
		for (i = 0; i < 6 && irq !== 1'b1; i++) @(negedge clock_i);
		chk(irq, "irq on rise");
		chk(oe && line_n === 1'b0, "line not driven");
		chk(thr === 2'b11, "no throttle");
		@(negedge clock_i);
		chk(irq === 1'b0, "irq not a pulse");
	endtask
	task automatic cool_down();
		cfg.irq_mode = TAC_IRQ_DEASSERT;
		sense.at_max = 2'b00;
		for (i = 0; i < 6 && irq !== 1'b1; i++) @(negedge clock_i);
		chk(irq, "irq on fall");
		chk(thr === 2'b11, "throttle dropped early");
		for (i = 0; i < 12 && thr !== 2'b00; i++) @(negedge clock_i);
		chk(thr === 2'b00, "throttle stuck");
	endtask
	task automatic board_request();
		cfg.irq_mode = TAC_IRQ_BOTH;
		req = 1'b1;
		for (i = 0; i < 8 && thr !== 2'b11; i++) @(negedge clock_i);
		chk(thr === 2'b11 && oe === 1'b0, "request ignored");
		repeat (10) @(negedge clock_i);
		chk(thr === 2'b11 && irq === 1'b0, "forced throttle lost");
		req = 1'b0;
		for (i = 0; i < 12 && thr !== 2'b00; i++) @(negedge clock_i);
		chk(thr === 2'b00, "held after release");
	endtask
	task automatic trip();
		cfg = '{1'b0, TAC_IRQ_BOTH};
		sense = '{2'b10, 2'b10};
		for (i = 0; i < 6 && irq !== 1'b1; i++) @(negedge clock_i);
		chk(irq, "irq in both-edge mode");
		repeat (3) @(negedge clock_i);
		chk(oe === 1'b1 && thr === 2'b00, "alarm with no throttle");
		chk(shut_n === 1'b0 && halt === 1'b1, "no shutdown");
		sense = '0;
		repeat (5) @(negedge clock_i);
		chk(shut_n === 1'b0 && supply_off, "trip not latched");
		chk(fan === FAN_OFFSET_MAX, "fan offset not clamped");
	endtask
	// Free-running core clock
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	// Reset, then the scenarios in turn
	initial begin
		rst_n_i = 1'b0;
		req = 1'b0;
		cfg = '{1'b0, TAC_IRQ_OFF};
		sense = '0;
		repeat (20) @(negedge clock_i);
		chk(shut_n === 1'b1 && oe === 1'b0 && thr === 2'b00, "reset");
		rst_n_i = 1'b1;
		@(negedge clock_i);
		own_alarm();
		cool_down();
		board_request();
		trip();
		final_report();
	end
	// Hang guard
	initial begin
		#100000;
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
